// *** core/php_parallel_port.sv ***
// parallel host port: latched 24-bit data port with strobe/output-enable handshake
// assumes a classic Wishbone master on clk and an external party on the pins
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "php_consts.svh"
module php_parallel_port (
  input wire logic clk, // system clock, 100 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [7:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  output logic irq, // level interrupt
  input wire logic [23:0] dataIn, // data pins, input side
  output logic [23:0] dataOut, // data pins, output side
  output logic [23:0] dataOe, // data pins, output enable per bit
  input wire logic write_strobe_n, // external write strobe
  input wire logic output_enable_n, // external output enable
  input wire logic chip_select_n, // external chip select
  output logic output_ready_pin, // data ready pin
  output logic latch_vacant_pin, // latch empty pin
  output logic hsPinOe // handshake output pins enable
);
  import php_pkg::*;

  php_state_s st_r;
  php_state_s st_nxt;
  php_pin_if pinBus ();
  logic rdAct;
  logic wrAct;
  logic readEnd;
  logic writeEnd;
  logic acc;
  logic wrEn;
  logic rdEn;
  logic [5:0] adrW;
  logic [23:0] pinData;
  logic [1:0] irqClr;

  // ==========================================
  // pin synchroniser

  php_pin_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pinsRaw({chip_select_n, output_enable_n, write_strobe_n, dataIn}),
    .pinBus(pinBus)
  );

  // ==========================================
  // helpers

  function automatic logic [23:0] laneMask(input php_width_e w);
    case (w)
      PHP_W8: laneMask = `PHP_MASK8;
      PHP_W16: laneMask = `PHP_MASK16;
      default: laneMask = `PHP_MASK24;
    endcase
  endfunction

  // flag bit reads opposite to its pin
  function automatic logic flagBit(input logic active, input logic pol);
    flagBit = ~(active ^ pol);
  endfunction

  // ==========================================
  // next state

  always_comb
  begin
    st_nxt = st_r;
    adrW = adr_i[7:2];
    pinData = pinBus.level[23:0];
    acc = cyc_i && stb_i && st_r.ack;
    wrEn = acc && we_i && sel_i[0];
    rdEn = acc && !we_i;
    // handshake inputs count only under chip select
    rdAct = st_r.enable && !pinBus.level[`PHP_PIN_CS] && !pinBus.level[`PHP_PIN_OE];
    wrAct = st_r.enable && !pinBus.level[`PHP_PIN_CS] && !pinBus.level[`PHP_PIN_STB];
    readEnd = st_r.prevRead && !rdAct && pinBus.level[`PHP_PIN_OE];
    writeEnd = st_r.prevWrite && !wrAct && pinBus.level[`PHP_PIN_STB];
    st_nxt.prevRead = rdAct;
    st_nxt.prevWrite = wrAct;
    irqClr = 2'h0;

    // bus answer: ack one cycle after the request, then dropped
    st_nxt.ack = cyc_i && stb_i && !st_r.ack;
    st_nxt.datO = 32'h00000000;
    if (st_nxt.ack && !we_i)
    begin
      case (adrW)
        `PHP_ADR_CFG: st_nxt.datO[7:0] = {2'h0, st_r.vacPol, st_r.rdyPol,
          flagBit(st_r.latchVacant, st_r.vacPol), flagBit(st_r.dataReady, st_r.rdyPol), st_r.width};
        `PHP_ADR_PORT0: st_nxt.datO[7:0] = st_r.inLatch[7:0];
        `PHP_ADR_PORT1: st_nxt.datO[7:0] = st_r.inLatch[15:8];
        `PHP_ADR_PORT2: st_nxt.datO[7:0] = st_r.inLatch[23:16];
        `PHP_ADR_ISTAT: st_nxt.datO[1:0] = st_r.irqStat;
        `PHP_ADR_IMASK: st_nxt.datO[1:0] = st_r.irqMask;
        `PHP_ADR_CTRL: st_nxt.datO[0] = st_r.enable;
        default: st_nxt.datO = 32'h00000000;
      endcase
    end

    // register writes take effect on the acknowledged edge
    if (wrEn)
    begin
      case (adrW)
        `PHP_ADR_CFG:
        begin
          st_nxt.width = php_width_e'(dat_i[1:0]);
          st_nxt.rdyPol = dat_i[`PHP_CFG_RPOL];
          st_nxt.vacPol = dat_i[`PHP_CFG_VPOL];
        end
        `PHP_ADR_PORT0: st_nxt.outLatch[7:0] = dat_i[7:0];
        `PHP_ADR_PORT1: st_nxt.outLatch[15:8] = dat_i[7:0];
        `PHP_ADR_PORT2: st_nxt.outLatch[23:16] = dat_i[7:0];
        `PHP_ADR_ISTAT: irqClr = dat_i[1:0];
        `PHP_ADR_IMASK: st_nxt.irqMask = dat_i[1:0];
        `PHP_ADR_CTRL: st_nxt.enable = dat_i[`PHP_CTRL_EN];
        default: irqClr = 2'h0;
      endcase
    end

    // flags: the firmware set wins over a same-cycle pin clear
    if (rdAct)
    begin
      st_nxt.dataReady = 1'b0;
    end
    if (wrAct)
    begin
      st_nxt.latchVacant = 1'b0;
    end
    if (wrEn && adrW == `PHP_ADR_PORT0)
    begin
      st_nxt.dataReady = 1'b1;
    end
    if (rdEn && adrW == `PHP_ADR_PORT0)
    begin
      st_nxt.latchVacant = 1'b1;
    end

    // capture the pin word as strobe rises
    if (writeEnd)
    begin
      st_nxt.inLatch = pinData & laneMask(st_r.width);
    end

    // sticky events, write-one-to-clear, set beats clear
    st_nxt.irqStat = (st_r.irqStat & ~irqClr) | {writeEnd, readEnd};
    st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);

    // pins follow the next state so flag and pin never disagree
    st_nxt.readyPin = st_nxt.dataReady ^ st_nxt.rdyPol;
    st_nxt.vacantPin = st_nxt.latchVacant ^ st_nxt.vacPol;
    st_nxt.hsOe = st_nxt.enable;
    st_nxt.dataOe = rdAct ? laneMask(st_r.width) : 24'h000000;
  end

  // ==========================================
  // state register

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.latchVacant <= `PHP_RST_VACANT;
      st_r.dataReady <= `PHP_RST_READY;
      st_r.vacantPin <= `PHP_RST_VACANT;
      st_r.readyPin <= `PHP_RST_READY;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs, all straight from flops

  assign dat_o = st_r.datO;
  assign ack_o = st_r.ack;
  assign irq = st_r.irq;
  assign dataOut = st_r.outLatch;
  assign dataOe = st_r.dataOe;
  assign output_ready_pin = st_r.readyPin;
  assign latch_vacant_pin = st_r.vacantPin;
  assign hsPinOe = st_r.hsOe;

  // ==========================================
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_port0Write;
    wrEn && adrW == `PHP_ADR_PORT0;
  endsequence

  sequence s_readDone;
    rdAct ##1 (!rdAct && pinBus.level[`PHP_PIN_OE]);
  endsequence

  sequence s_writeDone;
    wrAct ##1 (!wrAct && pinBus.level[`PHP_PIN_STB]);
  endsequence

  a_ready_on_port0: assert property (s_port0Write |=> st_r.dataReady ##1 output_ready_pin == !st_r.rdyPol)
    else $error("data ready not raised by port 0 write");

  a_ready_only_port0: assert property ($rose(st_r.dataReady) |-> $past(wrEn) && $past(adrW) == `PHP_ADR_PORT0)
    else $error("data ready raised without port 0 write");

  a_vacant_only_read: assert property ($rose(st_r.latchVacant) |-> $past(rdEn) && $past(adrW) == `PHP_ADR_PORT0)
    else $error("latch empty raised without port 0 read");

  a_ready_clear: assert property (rdAct && !(wrEn && adrW == `PHP_ADR_PORT0) |=> !st_r.dataReady)
    else $error("data ready not cleared by output enable");

  a_vacant_clear: assert property (wrAct && !(rdEn && adrW == `PHP_ADR_PORT0) |=> !st_r.latchVacant)
    else $error("latch empty not cleared by strobe");

  a_ready_polarity: assert property (output_ready_pin == (st_r.dataReady ^ st_r.rdyPol))
    else $error("ready pin polarity wrong");

  a_vacant_polarity: assert property (latch_vacant_pin != flagBit(st_r.latchVacant, st_r.vacPol))
    else $error("vacant flag does not read opposite pin");

  a_read_irq: assert property (s_readDone |=> st_r.irqStat[`PHP_IRQ_RD])
    else $error("read completion did not set status");

  a_write_irq: assert property (s_writeDone |=> st_r.irqStat[`PHP_IRQ_WR])
    else $error("write completion did not set status");

  a_write_capture: assert property (s_writeDone |=> st_r.inLatch == ($past(pinData) & laneMask(st_r.width)))
    else $error("input latch did not capture pins");

  a_read_drive: assert property (rdAct |=> dataOe == laneMask($past(st_r.width)) && dataOut == st_r.outLatch)
    else $error("data not driven during external read");

  // handshake enable tracks the control bit; a same-cycle enable write must not trip it
  a_idle_quiet: assert property (!st_r.enable |=> dataOe == 24'h000000 ##0 hsPinOe == st_r.enable)
    else $error("pins driven while port disabled");

  a_gated_cs: assert property (pinBus.level[`PHP_PIN_CS] |-> !rdAct && !wrAct)
    else $error("handshake honoured without chip select");

  a_width_lanes: assert property ((dataOe & ~`PHP_MASK8) != 24'h000000 |-> $past(st_r.width) != PHP_W8)
    else $error("lanes beyond width driven");

  a_wb_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");

  a_irq_level: assert property (irq == |(st_r.irqStat & st_r.irqMask))
    else $error("interrupt output not matching status");

  // read data is only valid in the ack cycle, zero otherwise
  a_wb_data_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data not zero outside ack");

  // flags move only on their own set or clear events
  a_ready_hold: assert property (!rdAct && !(wrEn && adrW == `PHP_ADR_PORT0) |=> $stable(st_r.dataReady))
    else $error("data ready changed without cause");

  a_vacant_hold: assert property (!wrAct && !(rdEn && adrW == `PHP_ADR_PORT0) |=> $stable(st_r.latchVacant))
    else $error("latch empty changed without cause");

  // input latch only changes at a completed external write
  a_latch_hold: assert property (!writeEnd |=> $stable(st_r.inLatch))
    else $error("input latch changed outside write end");

endmodule
`default_nettype wire

// *** core/php_consts.svh ***
// offsets, field positions, reset values and pin indices of the parallel host port
// assumes a 32-bit classic Wishbone slave, byte addresses, 8-bit registers in lane 0
`ifndef PHP_CONSTS_SVH
`define PHP_CONSTS_SVH

// ==========================================
// register word offsets, compared with adr_i[7:2]
`define PHP_ADR_CFG 6'h00
`define PHP_ADR_PORT0 6'h01
`define PHP_ADR_PORT1 6'h02
`define PHP_ADR_PORT2 6'h03
`define PHP_ADR_ISTAT 6'h04
`define PHP_ADR_IMASK 6'h05
`define PHP_ADR_CTRL 6'h06

// ==========================================
// configuration, control and interrupt fields
`define PHP_CFG_READY 2
`define PHP_CFG_VACANT 3
`define PHP_CFG_RPOL 4
`define PHP_CFG_VPOL 5
`define PHP_CTRL_EN 0
`define PHP_IRQ_RD 0
`define PHP_IRQ_WR 1

// ==========================================
// reset values
`define PHP_RST_VACANT 1'b1
`define PHP_RST_READY 1'b0
`define PHP_PIN_IDLE 27'h7000000

// ==========================================
// synchronised pin vector layout
`define PHP_PIN_STB 24
`define PHP_PIN_OE 25
`define PHP_PIN_CS 26
`define PHP_MASK8 24'h0000FF
`define PHP_MASK16 24'h00FFFF
`define PHP_MASK24 24'hFFFFFF

`endif

// *** core/php_pkg.sv ***
// types shared by the parallel host port modules
// assumes php_consts.svh is on the include path
package php_pkg;

  typedef enum logic [1:0] {PHP_W8, PHP_W16, PHP_W24, PHP_W24B} php_width_e;

  typedef logic [26:0] php_pins_t;

  typedef struct packed {
    php_pins_t s1;
    php_pins_t s2;
    php_pins_t s3;
    php_pins_t level;
  } php_sync_s;

  typedef struct packed {
    php_width_e width;
    logic rdyPol;
    logic vacPol;
    logic enable;
    logic dataReady;
    logic latchVacant;
    logic [23:0] outLatch;
    logic [23:0] inLatch;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic prevRead;
    logic prevWrite;
    logic ack;
    logic [31:0] datO;
    logic irq;
    logic readyPin;
    logic vacantPin;
    logic hsOe;
    logic [23:0] dataOe;
  } php_state_s;

endpackage

// *** core/php_pin_if.sv ***
// carrier of the synchronised pin levels between the synchroniser and the port core
// assumes one clock domain on both ends
`timescale 1ns/10ps
`default_nettype none
interface php_pin_if;
  php_pkg::php_pins_t level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

// *** core/php_pin_sync.sv ***
// three-stage synchroniser for the data and handshake pins
// assumes asynchronous pin inputs; a bit changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
`include "php_consts.svh"
module php_pin_sync (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire php_pkg::php_pins_t pinsRaw, // raw pin levels
  php_pin_if.src pinBus // filtered levels
);
  import php_pkg::*;

  php_sync_s st_r;
  php_sync_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pinsRaw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // only stages two and three feed the filter
    st_nxt.level = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.level & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r.s1 <= `PHP_PIN_IDLE;
      st_r.s2 <= `PHP_PIN_IDLE;
      st_r.s3 <= `PHP_PIN_IDLE;
      st_r.level <= `PHP_PIN_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pinBus.level = st_r.level;

endmodule
`default_nettype wire

// *** verification/php_host_model.sv ***
// external microcontroller model on the strobe/output-enable/chip-select pins
// assumes the bench resolves the data pads from the port's dataOe alone, this party driving every bit not enabled
`timescale 1ns/10ps
`default_nettype none
module php_host_model (
  input wire logic clk, // system clock
  input wire logic [23:0] padBus, // resolved data pads
  output logic [23:0] hostData, // data this party drives
  output logic write_strobe_n, // write strobe
  output logic output_enable_n, // output enable
  output logic chip_select_n // chip select
);
  initial
  begin
    hostData = 24'h000000;
    write_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    chip_select_n = 1'b1;
  end

  // ==========================================
  // external write; sel low leaves chip select high
  task ext_write(input logic [23:0] d, input logic sel, input int hold);
    @(posedge clk);
    chip_select_n <= ~sel;
    hostData <= d;
    write_strobe_n <= 1'b0;
    repeat (hold) @(posedge clk);
    write_strobe_n <= 1'b1;
    // data held past strobe rise so the capture sees it
    repeat (hold) @(posedge clk);
    chip_select_n <= 1'b1;
    // released pads must not keep showing the last word
    hostData <= ~d;
  endtask

  // ==========================================
  // external read; output enable released before chip select
  task ext_read(output logic [23:0] q, input int hold);
    @(posedge clk);
    chip_select_n <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (hold) @(posedge clk);
    q = padBus;
    output_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_parallel_host_handshake_port.sv ***
// self-checking bench of the parallel host port against a flag/status model
// assumes php_consts.svh on the include path and the host model beside it
`timescale 1ns/10ps
`default_nettype none
`include "php_consts.svh"
module tb_parallel_host_handshake_port;
  localparam logic [7:0] A_CFG = {`PHP_ADR_CFG, 2'b00};
  localparam logic [7:0] A_P0 = {`PHP_ADR_PORT0, 2'b00};
  localparam logic [7:0] A_P1 = {`PHP_ADR_PORT1, 2'b00};
  localparam logic [7:0] A_P2 = {`PHP_ADR_PORT2, 2'b00};
  localparam logic [7:0] A_IST = {`PHP_ADR_ISTAT, 2'b00};
  localparam logic [7:0] A_IMK = {`PHP_ADR_IMASK, 2'b00};
  localparam logic [7:0] A_CTL = {`PHP_ADR_CTRL, 2'b00};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o, irq, output_ready_pin, latch_vacant_pin, hsPinOe;
  logic [23:0] dataOut, dataOe, hostData, padBus;
  logic write_strobe_n, output_enable_n, chip_select_n;
  int n_fail = 0;
  int samples_checked = 0;
  int w;
  logic rdy = 1'b0;
  logic vac = 1'b1;
  logic rpol = 1'b0;
  logic vpol = 1'b0;
  logic [1:0] wd = 2'b00;
  logic [7:0] q;
  logic [23:0] d, rq, m;

  always #5 clk = ~clk;
  assign padBus = (dataOe & dataOut) | (~dataOe & hostData);

  php_parallel_port dut_u (.clk(clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq(irq), .dataIn(padBus), .dataOut(dataOut),
    .dataOe(dataOe), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .chip_select_n(chip_select_n), .output_ready_pin(output_ready_pin), .latch_vacant_pin(latch_vacant_pin),
    .hsPinOe(hsPinOe));

  php_host_model host_u (.clk(clk), .padBus(padBus), .hostData(hostData), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .chip_select_n(chip_select_n));

  // ==========================================
  // checking and closing
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] cfg_exp();
    return {2'b00, vpol, rpol, ~(vac ^ vpol), ~(rdy ^ rpol), wd};
  endfunction

  // ==========================================
  // classic wishbone single cycle, no fixed latency assumed
  task wb(input logic wr, input logic [7:0] a, input logic [7:0] dv, output logic [7:0] rv);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= {24'h000000, dv};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      chk("bus ack", 32'h0, 32'h1);
    rv = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task pins_and_cfg;
    repeat (2) @(posedge clk);
    chk("ready pin", output_ready_pin, rdy ^ rpol);
    chk("vacant pin", latch_vacant_pin, vac ^ vpol);
    wb(1'b0, A_CFG, 8'h00, q);
    chk("cfg", q, cfg_exp());
  endtask

  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end

  initial
  begin
    void'($urandom(35));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    pins_and_cfg();
    wb(1'b0, 8'h1C, 8'h00, q);
    chk("unmapped", q, 8'h00);
    wb(1'b1, A_CTL, 8'h01, q);
    wb(1'b1, A_IMK, 8'h03, q);
    chk("hs oe", hsPinOe, 1'b1);
    $display("reset and setup done");
    for (w = 0; w < 3; w++)
    begin
      wd = w[1:0];
      m = (w == 0) ? 24'h0000FF : (w == 1) ? 24'h00FFFF : 24'hFFFFFF;
      wb(1'b1, A_CFG, {6'h00, wd}, q);
      d = $urandom;
      wb(1'b1, A_P2, d[23:16], q);
      wb(1'b1, A_P1, d[15:8], q);
      pins_and_cfg();
      wb(1'b1, A_P0, d[7:0], q);
      rdy = 1'b1;
      pins_and_cfg();
      host_u.ext_read(rq, 8 + w * 4);
      rdy = 1'b0;
      chk("read word", rq & m, d & m);
      repeat (8) @(posedge clk);
      wb(1'b0, A_IST, 8'h00, q);
      chk("read done", q, 8'h01);
      chk("irq", irq, 1'b1);
      wb(1'b1, A_IST, 8'h01, q);
      d = $urandom;
      host_u.ext_write(d, 1'b1, 6);
      vac = 1'b0;
      repeat (8) @(posedge clk);
      wb(1'b0, A_IST, 8'h00, q);
      chk("write done", q, 8'h02);
      pins_and_cfg();
      d = d & m;
      wb(1'b0, A_P1, 8'h00, q);
      chk("port1", q, d[15:8]);
      wb(1'b0, A_P2, 8'h00, q);
      chk("port2", q, d[23:16]);
      pins_and_cfg();
      wb(1'b0, A_P0, 8'h00, q);
      chk("port0", q, d[7:0]);
      vac = 1'b1;
      pins_and_cfg();
      wb(1'b1, A_IST, 8'h02, q);
      repeat (2) @(posedge clk);
      chk("irq clear", irq, 1'b0);
      $display("width %0d done", w);
    end
    // read-only flags and upper bits ignore the write
    wb(1'b1, A_CFG, 8'hFC, q);
    wd = 2'b00;
    rpol = 1'b1;
    vpol = 1'b1;
    pins_and_cfg();
    host_u.ext_write($urandom, 1'b0, 6);
    repeat (8) @(posedge clk);
    wb(1'b0, A_IST, 8'h00, q);
    chk("no select", q, 8'h00);
    pins_and_cfg();
    wb(1'b1, A_IMK, 8'h00, q);
    host_u.ext_read(rq, 8);
    repeat (8) @(posedge clk);
    chk("masked irq", irq, 1'b0);
    wb(1'b1, A_IMK, 8'h01, q);
    repeat (2) @(posedge clk);
    chk("unmasked irq", irq, 1'b1);
    wb(1'b1, A_IST, 8'h01, q);
    repeat (2) @(posedge clk);
    chk("cleared irq", irq, 1'b0);
    $display("polarity, select and mask done");
    final_report();
  end
endmodule
`default_nettype wire
